// [rtl/dsb_fifo.sv]
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes both sides run on ref_clk; depth is a power of two.
 */
`timescale 1ns/1ps
module dsb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [PW:0]      wr_q, wr_d, rd_q, rd_d;
    logic             push, pop;

    // pointer arithmetic with one wrap bit
    always_comb begin
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? wr_q + 1'b1 : wr_q;
        rd_d      = pop ? rd_q + 1'b1 : rd_q;
        in_ready  = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
        out_valid = wr_q != rd_q;
        out_data  = mem_q[rd_q[PW-1:0]];
    end

    // pointers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // storage
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q[PW-1:0]] <= in_data;
        end
    end

endmodule : dsb_fifo

// [rtl/dsb_sram_port.sv]
/*
 * port logic of a two-word burst sram with separate ddr read and write
 * ports on one address bus, oversampling the link clocks on ref_clk.
 * assumes link clocks far slower than ref_clk (at least 4 ref cycles
 * per link half period) and straps stable from reset release.
 */
// Functional notes
// - a write starts on an input clock rise with write select low, word 0 taken there, word 1 on the next complementary rise.
// - a read started at t drives word 0 on the complementary output rise of t+1 and word 1 on the output rise of t+2.
//   with the latency strap high a read started at t+1 and promoted by that rise drops that word 1.
// - after reset both ports are idle and the read data outputs are high impedance.
// - the address latched at the start is the burst base: beat 0 to base, beat 1 to the next burst location.
// - write data is taken on both input clock rises, read data launched on output clock rises or input clock rises in single clock mode.
//   the port logic launches word 0 at short latency on the input clock rise, outside single clock mode too.
// - at 18 bits select 0 gates bits 8..0 and select 1 bits 17..9, a high select keeps the lane.
// - at 9 bits one select gates the whole word per beat.
// - at 36 bits four selects gate one nine bit lane each, select 3 the top lane.
// - a beat with every select high stores nothing while the other beat proceeds.
// - with the latency strap low read data comes one cycle after the request instead of one and a half.
// - a read of a location written by the write started on the previous rise returns the new data.
`timescale 1ns/1ps
module dsb_sram_port #(
    parameter int DATA_W = dsb_pkg::DATA_W,
    parameter int ADDR_W = dsb_pkg::ADDR_W,
    parameter int DEPTH  = dsb_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    // controller pins
    input  wire dsb_pkg::dsb_pins_t        pins,
    // read port pins
    output logic [dsb_pkg::DATA_W-1:0]     rd_data_q,
    output logic                           rd_oe_q,
    // write buffer able to take a beat
    output logic                           wbuf_ready_q
);
    import dsb_pkg::*;

    typedef enum logic [1:0] {PH_NONE, PH_W0, PH_W1, PH_DONE} dsb_phase_t;

    // lane mask check used for both beats
    function automatic logic dsb_any_lane(input logic [LANES-1:0] sel_n);
        dsb_any_lane = ~&sel_n;
    endfunction : dsb_any_lane

    // two-stage synchroniser plus one history stage for edge finding
    logic [PINS_W-1:0] sync1_q, sync2_q, hist_q;
    dsb_pins_t         p, ph;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '1;
            sync2_q <= '1;
            hist_q  <= '1;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            hist_q  <= sync2_q;
        end
    end

    // strap capture state, declared ahead of the edge logic that reads it
    logic [1:0] strap_cnt_q;
    logic       dll_q, single_q;

    // edges of the link clocks after synchronising
    logic k_rise, kn_rise, o_rise, on_rise;
    always_comb begin
        p       = dsb_pins_t'(sync2_q);
        ph      = dsb_pins_t'(hist_q);
        k_rise  = p.in_clk && !ph.in_clk;
        kn_rise = p.in_clk_n && !ph.in_clk_n;
        o_rise  = single_q ? k_rise : (p.out_clk && !ph.out_clk);
        on_rise = single_q ? kn_rise : (p.out_clk_n && !ph.out_clk_n);
    end

    // strap capture on the third edge after release, once sync2 holds real pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_q <= 2'h0;
            dll_q       <= 1'b1;
            single_q    <= 1'b0;
        end else if (strap_cnt_q != 2'h3) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == 2'h2) begin
                dll_q    <= p.latency_mode_strap;
                single_q <= p.single_clock_strap;
            end
        end
    end

    // write side: beat capture into the buffer
    logic              wpend_q, wpend_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic              push;
    dsb_beat_t         beat;
    logic              fill_rdy, drain_vld, drain_rdy;
    dsb_beat_t         drain_beat;
    logic [BEAT_W-1:0] drain_raw;

    always_comb begin
        wpend_d = wpend_q;
        waddr_d = waddr_q;
        push    = 1'b0;
        beat    = '0;
        if (k_rise) begin
            wpend_d = !p.write_port_select_n;
            if (!p.write_port_select_n) begin
                waddr_d     = p.addr;
                beat.addr   = {p.addr, 1'b0};
                beat.data   = p.wdata;
                beat.lane_n = p.byte_lane_write_select_n;
                push        = dsb_any_lane(p.byte_lane_write_select_n);
            end
        end else if (kn_rise && wpend_q) begin
            wpend_d     = 1'b0;
            beat.addr   = {waddr_q, 1'b1};
            beat.data   = p.wdata;
            beat.lane_n = p.byte_lane_write_select_n;
            push        = dsb_any_lane(p.byte_lane_write_select_n);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wpend_q      <= 1'b0;
            waddr_q      <= '0;
            wbuf_ready_q <= WB_RDY_RST;
        end else begin
            wpend_q      <= wpend_d;
            waddr_q      <= waddr_d;
            wbuf_ready_q <= fill_rdy;
        end
    end

    dsb_fifo #(
        .WIDTH (BEAT_W),
        .DEPTH (DEPTH)
    ) u_wbuf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (fill_rdy),
        .in_data   (beat),
        .out_valid (drain_vld),
        .out_ready (drain_rdy),
        .out_data  (drain_raw)
    );

    // read side: one pending request and one active burst
    logic              pend_q, pend_d, pend_armed_q, pend_armed_d;
    logic [ADDR_W-1:0] raddr_q, raddr_d;
    logic [1:0]        fetch_q, fetch_d;
    logic              fetch_en;
    logic [DATA_W-1:0] pbuf_q [0:1];
    logic [DATA_W-1:0] abuf_q [0:1];
    dsb_phase_t        ph_q, ph_d;
    logic [DATA_W-1:0] rd_data_d;
    logic              rd_oe_d, promote;

    // array fetch waits for an empty buffer so pending writes land first
    always_comb begin
        drain_beat   = dsb_beat_t'(drain_raw);
        drain_rdy    = fetch_q == 2'h0 || !pend_armed_q;
        fetch_en     = pend_armed_q && fetch_q != 2'h2 && !drain_vld;
        fetch_d      = fetch_en ? fetch_q + 2'h1 : fetch_q;
        pend_d       = pend_q;
        pend_armed_d = pend_armed_q || (pend_q && kn_rise);
        raddr_d      = raddr_q;
        promote      = k_rise && pend_q;
        if (k_rise) begin
            pend_d       = !p.read_port_select_n;
            pend_armed_d = 1'b0;
            fetch_d      = 2'h0;
            if (!p.read_port_select_n) begin
                raddr_d = p.addr;
            end
        end
    end

    // output launch schedule
    always_comb begin
        ph_d      = ph_q;
        rd_data_d = rd_data_q;
        rd_oe_d   = rd_oe_q;
        if (promote && !dll_q) begin
            ph_d      = PH_W1;
            rd_data_d = pbuf_q[0];
            rd_oe_d   = 1'b1;
        end else if (promote) begin
            ph_d = PH_W0;
        end else if (on_rise) begin
            if (ph_q == PH_W0) begin
                ph_d      = PH_W1;
                rd_data_d = abuf_q[0];
                rd_oe_d   = 1'b1;
            end else if (ph_q == PH_W1 && !dll_q) begin
                ph_d      = PH_DONE;
                rd_data_d = abuf_q[1];
            end else begin
                rd_oe_d = ph_q == PH_W1;
                if (ph_q == PH_DONE) begin
                    ph_d = PH_NONE;
                end
            end
        end else if (o_rise) begin
            if (ph_q == PH_W1 && dll_q) begin
                ph_d      = PH_DONE;
                rd_data_d = abuf_q[1];
            end else if (ph_q == PH_DONE) begin
                ph_d    = PH_NONE;
                rd_oe_d = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q       <= 1'b0;
            pend_armed_q <= 1'b0;
            raddr_q      <= '0;
            fetch_q      <= 2'h0;
            ph_q         <= PH_NONE;
            rd_data_q    <= RD_DATA_RST;
            rd_oe_q      <= RD_OE_RST;
        end else begin
            pend_q       <= pend_d;
            pend_armed_q <= pend_armed_d;
            raddr_q      <= raddr_d;
            fetch_q      <= fetch_d;
            ph_q         <= ph_d;
            rd_data_q    <= rd_data_d;
            rd_oe_q      <= rd_oe_d;
        end
    end

    // memory array with per-lane write gating
    logic [DATA_W-1:0] mem_q [0:(2**(ADDR_W+1))-1];
    always_ff @(posedge ref_clk) begin
        if (drain_vld && drain_rdy) begin
            for (int l = 0; l < LANES; l++) begin
                if (!drain_beat.lane_n[l]) begin
                    mem_q[drain_beat.addr][l*LANE_W +: LANE_W]
                        <= drain_beat.data[l*LANE_W +: LANE_W];
                end
            end
        end
        if (fetch_en) begin
            pbuf_q[fetch_q[0]] <= mem_q[{raddr_q, fetch_q[0]}];
        end
        if (promote) begin
            abuf_q[0] <= pbuf_q[0];
            abuf_q[1] <= pbuf_q[1];
        end
    end

endmodule : dsb_sram_port

// [shared/dsb_pkg.sv]
/*
 * package of the burst sram port block: widths, reset values and the
 * packed carriers shared by the port logic and its write buffer.
 * assumes a single reference clock that oversamples every link pin.
 */
package dsb_pkg;

    // data word, lane and address widths (9, 18 or 36 bit words)
    localparam int DATA_W     = 18;
    localparam int LANE_W     = 9;
    localparam int LANES      = DATA_W / LANE_W;
    localparam int ADDR_W     = 8;
    localparam int FIFO_DEPTH = 8;

    // reset values of the read output pins and the write buffer ready flag
    localparam logic [DATA_W-1:0] RD_DATA_RST = 18'h00000;
    localparam logic              RD_OE_RST   = 1'b0;
    localparam logic              WB_RDY_RST  = 1'b0;

    // pins from the memory controller, all outside the ref_clk domain
    typedef struct packed {
        logic              in_clk;
        logic              in_clk_n;
        logic              out_clk;
        logic              out_clk_n;
        logic              read_port_select_n;
        logic              write_port_select_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0]  byte_lane_write_select_n;
        logic              latency_mode_strap;
        logic              single_clock_strap;
    } dsb_pins_t;

    // one write beat waiting for the array
    typedef struct packed {
        logic [ADDR_W:0]   addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  lane_n;
    } dsb_beat_t;

    localparam int PINS_W = $bits(dsb_pins_t);
    localparam int BEAT_W = $bits(dsb_beat_t);

endpackage : dsb_pkg

// [verif/dsb_ctrl_model.sv]
/* memory controller model: link clocks, selects, address, write beats.
   assumes the bench steps it through cmd and idle calls. */
`timescale 1ns/1ps
module dsb_ctrl_model (
    // bench controls
    input wire logic          run,
    input wire logic          lat_strap,
    // link pins
    output dsb_pkg::dsb_pins_t pins
);
    import dsb_pkg::*;
    logic              k;
    logic              rps_n;
    logic              wps_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd;
    logic [LANES-1:0]  bw_n;

    // output clocks mirror the input pair, single clock mode off
    assign pins = '{in_clk: k, in_clk_n: ~k, out_clk: k, out_clk_n: ~k,
                    read_port_select_n: rps_n, write_port_select_n: wps_n,
                    addr: addr, wdata: wd, byte_lane_write_select_n: bw_n,
                    latency_mode_strap: lat_strap, single_clock_strap: 1'b0};

    // 320 ns link clock, halts where it stands while run is low
    initial begin
        k = 1'b0;
        rps_n = 1'b1;
        wps_n = 1'b1;
        addr = '0;
        wd = '0;
        bw_n = '1;
        #13;
        forever begin
            #160;
            if (run) k = ~k;
        end
    end

    // one link cycle: beat 0 held over the rise, beat 1 over the fall
    task cmd(input logic r, input logic w, input logic [ADDR_W-1:0] a,
             input logic [DATA_W-1:0] d0, input logic [LANES-1:0] m0,
             input logic [DATA_W-1:0] d1, input logic [LANES-1:0] m1);
        @(negedge k);
        #50;
        rps_n = ~r;
        wps_n = ~w;
        addr = a;
        wd = d0;
        bw_n = m0;
        @(posedge k);
        #50;
        rps_n = 1'b1;
        wps_n = 1'b1;
        addr = ~a;
        wd = d1;
        bw_n = m1;
    endtask : cmd

    // stale lines toggle so old values never look valid
    task idle();
        @(negedge k);
        #50;
        wd = ~wd;
        bw_n = ~bw_n;
        addr = ~addr;
    endtask : idle
endmodule : dsb_ctrl_model

// [verif/dsb_port_monitor.sv]
/* checker of the burst sram port pins: read latency, float and hold.
   assumes a link half period of four or more ref_clk cycles. */
`timescale 1ns/1ps
module dsb_port_checker (
    // clock and reset
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    // watched ports
    input wire dsb_pkg::dsb_pins_t         pins,
    input wire logic [dsb_pkg::DATA_W-1:0] rd_data_q,
    input wire logic                       rd_oe_q,
    input wire logic                       wbuf_ready_q
);
    import dsb_pkg::*;
    logic       k_q;
    logic       rd_start;
    logic [1:0] rise_q;
    logic [1:0] rise_d;
    logic [3:0] still_q;
    logic [3:0] still_d;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // raw in_clk rises since the last read start, and ref cycles without a link edge
    always_comb begin
        rd_start = pins.in_clk && !k_q && !pins.read_port_select_n;
        rise_d = rise_q;
        if (rd_start) begin
            rise_d = 2'h0;
        end else if (pins.in_clk && !k_q && rise_q != 2'h3) begin
            rise_d = rise_q + 2'h1;
        end
        still_d = (pins.in_clk != k_q) ? 4'h0 : still_q + {3'h0, still_q != 4'hF};
    end

    // registers only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            k_q <= 1'b0;
            rise_q <= 2'h3;
            still_q <= 4'h0;
        end else begin
            k_q <= pins.in_clk;
            rise_q <= rise_d;
            still_q <= still_d;
        end
    end

    sequence s_float_dll;
        !rd_oe_q [*8] ##1 !rd_oe_q [*3];
    endsequence
    sequence s_float_short;
        !rd_oe_q [*7];
    endsequence
    property p_rst_float;
        $rose(rst_n) |-> !rd_oe_q [*4];
    endproperty
    property p_lat_dll;
        rd_start && pins.latency_mode_strap && !rd_oe_q |-> s_float_dll ##[1:8] rd_oe_q;
    endproperty
    property p_lat_short;
        rd_start && !pins.latency_mode_strap && !rd_oe_q |-> s_float_short ##[1:7] rd_oe_q;
    endproperty
    property p_word0_holds;
        $rose(rd_oe_q) |=> $stable(rd_data_q) [*2];
    endproperty
    property p_burst_len;
        $rose(rd_oe_q) |-> rd_oe_q [*7];
    endproperty
    property p_oe_cause;
        $rose(rd_oe_q) |-> rise_q == 2'h1;
    endproperty
    property p_oe_ends;
        rd_oe_q |-> rise_q != 2'h3;
    endproperty
    property p_hold_stopped;
        still_q >= 4'h8 |-> $stable(rd_data_q) && $stable(rd_oe_q);
    endproperty

    a_rst_float: assert property (p_rst_float) else $error("output driven after reset");
    a_lat_dll: assert property (p_lat_dll) else $error("long read latency off");
    a_lat_short: assert property (p_lat_short) else $error("short read latency off");
    a_word0_holds: assert property (p_word0_holds) else $error("first word unstable");
    a_burst_len: assert property (p_burst_len) else $error("burst cut short");
    a_oe_cause: assert property (p_oe_cause) else $error("output without read");
    a_oe_ends: assert property (p_oe_ends) else $error("output not released");
    a_hold_stopped: assert property (p_hold_stopped) else $error("outputs moved");
endmodule : dsb_port_checker

bind dsb_sram_port dsb_port_checker u_checker (
    .ref_clk(ref_clk), .rst_n(rst_n), .pins(pins),
    .rd_data_q(rd_data_q), .rd_oe_q(rd_oe_q), .wbuf_ready_q(wbuf_ready_q));

// [verif/testbench.sv]
/* self-checking bench of the burst sram port.
   assumes 18 bit words and the controller model on the link. */
`timescale 1ns/1ps
module testbench;
    import dsb_pkg::*;
    typedef struct packed {
        logic r;
        logic w;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d0;
        logic [LANES-1:0] m0;
        logic [DATA_W-1:0] d1;
        logic [LANES-1:0] m1;
        logic [DATA_W-1:0] e0;
        logic [DATA_W-1:0] e1;
    } dsb_tb_row_t;
    logic              ref_clk;
    logic              rst_n;
    logic              run;
    logic              lat_strap;
    dsb_pins_t         pins;
    logic [DATA_W-1:0] rd_data_q;
    logic              rd_oe_q;
    logic              wbuf_ready_q;
    int                failures = 0;
    int                checks_done = 0;
    int                cycles = 0;
    int                lat_lo = 12;
    int                lat_hi = 16;
    dsb_tb_row_t       rows [8];

    dsb_sram_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pins),
        .rd_data_q(rd_data_q), .rd_oe_q(rd_oe_q), .wbuf_ready_q(wbuf_ready_q));
    dsb_ctrl_model model (.run(run), .lat_strap(lat_strap), .pins(pins));

    // 25 MHz clock and cycle ceiling
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            summarize();
        end
    end

    task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task do_reset(input logic strap);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        run <= 1'b0;
        lat_strap <= strap;
        repeat (3) @(posedge ref_clk);
        chk(DATA_W'(rd_oe_q), DATA_W'(RD_OE_RST));
        chk(DATA_W'(wbuf_ready_q), DATA_W'(WB_RDY_RST));
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        run <= 1'b1;
        chk(DATA_W'(wbuf_ready_q), DATA_W'(1));
    endtask : do_reset

    // waits for the burst, optionally stopping the link after word 0
    task take_burst(input logic [DATA_W-1:0] e0, input logic [DATA_W-1:0] e1, input logic stop);
        int n;
        n = 0;
        while (rd_oe_q !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        chk(DATA_W'(n >= lat_lo && n <= lat_hi), DATA_W'(1));
        chk(rd_data_q, e0);
        if (stop) begin
            @(posedge ref_clk);
            run <= 1'b0;
            repeat (20) @(negedge ref_clk);
            chk(DATA_W'(rd_oe_q), DATA_W'(1));
            chk(rd_data_q, e0);
            @(posedge ref_clk);
            run <= 1'b1;
        end
        if (lat_strap) @(posedge pins.out_clk);
        else @(posedge pins.in_clk_n);
        repeat (4) @(negedge ref_clk);
        chk(rd_data_q, e1);
        model.idle();
    endtask : take_burst

    task do_row(input dsb_tb_row_t rw);
        model.cmd(rw.r, rw.w, rw.a, rw.d0, rw.m0, rw.d1, rw.m1);
        if (rw.r) take_burst(rw.e0, rw.e1, 1'b0);
    endtask : do_row

    task summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    // main sequence: rows back to back, then clock stop and short latency
    initial begin
        rst_n = 1'b0;
        run = 1'b0;
        lat_strap = 1'b1;
        rows[0] = '{1'b0,1'b1,8'h05,18'h12345,2'h0,18'h0ABCD,2'h0,18'h0,18'h0};
        rows[1] = '{1'b1,1'b0,8'h05,18'h0,2'h3,18'h0,2'h3,18'h12345,18'h0ABCD};
        rows[2] = '{1'b0,1'b1,8'h05,18'h3FFFF,2'h2,18'h0,2'h1,18'h0,18'h0};
        rows[3] = '{1'b1,1'b0,8'h05,18'h0,2'h3,18'h0,2'h3,18'h123FF,18'h001CD};
        rows[4] = '{1'b0,1'b1,8'h05,18'h0,2'h3,18'h3FFFF,2'h0,18'h0,18'h0};
        rows[5] = '{1'b1,1'b0,8'h05,18'h0,2'h3,18'h0,2'h3,18'h123FF,18'h3FFFF};
        rows[6] = '{1'b1,1'b1,8'h0C,18'h2AAAA,2'h0,18'h15555,2'h0,18'h2AAAA,18'h15555};
        rows[7] = '{1'b1,1'b0,8'h05,18'h0,2'h3,18'h0,2'h3,18'h123FF,18'h3FFFF};
        do_reset(1'b1);
        $display("reset test done");
        foreach (rows[i]) do_row(rows[i]);
        $display("row tests done");
        model.cmd(1'b1, 1'b0, 8'h05, 18'h0, 2'h3, 18'h0, 2'h3);
        take_burst(18'h123FF, 18'h3FFFF, 1'b1);
        $display("clock stop test done");
        do_reset(1'b0);
        lat_lo = 7;
        lat_hi = 11;
        do_row(rows[0]);
        do_row(rows[1]);
        $display("short latency test done");
        summarize();
    end
endmodule : testbench
